// [verilog/rlws_map.vh]
// Constants for the reset and low-power wake sequencer: register offsets,
// field positions, reset values and cycle counts.
// Assumes clk_sys at 10 MHz; one clk_sys cycle is one core half-period.
//
// How it works
// R1 - Watchdog reset held 128 reference periods
// R2 - Reset vector 36 half-periods after lock
// R3 - Lock wait capped at 98304 reference periods
// R4 - Resume 12 or 15 core periods after wake
// R5 - Deep idle stops core clock high after 4; the code parks it high at entry
// R6 - Oscillator off 4 core periods after entry
// R7 - Halt wake restarts oscillator, waits for lock
// R8 - Reset vector 36 half-periods after pin high
// R9 - Enabled interrupt or reset ends idle modes
// R10 - Core clock off pin until mux bit 7
// R11 - Boot-enable phase samples test data input
// R12 - Next phase: test data or boot option
// R13 - Qualified low fault tri-states PWM output
// R14 - Board holds fault low 6 or 12
// R15 - Fault vector within 10 after pulse
// R16 - Halt wake restores saved clock multiplier
// R17 - Fault vector only when fault interrupt enabled
// R18 - PWM duty 0%, 100% or whole periods
// R19 - Watchdog drives reset pin low for pulse
// R20 - Every delay counter restarts from zero
`ifndef RLWS_MAP_VH
`define RLWS_MAP_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define A_MUX 8'h00
`define A_SCS2 8'h04
`define A_LPC 8'h08
`define A_IEN 8'h0c
`define A_PWM 8'h10
`define A_STAT 8'h14
`define A_MULT 8'h18

// ==========================================================
// Field positions and reset values
`define MUX_CLK_BIT 7
`define SCS2_QUAL_BIT 6
`define PWM_CMP_BIT 16
`define PWM_RST 32'h0001_0000
`define MULT_RST 2'h3

// ==========================================================
// Times in their own units and derived cycle counts
`define CLK_NS 100
`define REF_NS 100
`define CORE_HALF_NS 100
`define CORE_CYC(n) ((n) * 2 * `CORE_HALF_NS / `CLK_NS)
`define WD_PULSE_REF 128
`define WD_PULSE_CYC (`WD_PULSE_REF * `REF_NS / `CLK_NS)
`define VEC_HALVES 36
`define VEC_CYC (`VEC_HALVES * `CORE_HALF_NS / `CLK_NS)
`define LOCK_MAX_REF 98304
`define WAKE_LIGHT_CORE 12
`define WAKE_DEEP_CORE 15
`define STOP_CORE 4
`define QUAL_SHORT_CORE 6
`define QUAL_LONG_CORE 12
`define SYNC_CORE 1

`endif

// [verilog/reset_lowpower_wake_sequencer.v]
// Reset, low-power entry and wake sequencer with fault shutdown of PWM.
// Assumes all pins but arst_n are synchronous to clk_sys and a single AHB-Lite slave
// port; the board drives the reset pin, PLL lock and fault input.
`timescale 1ns/100ps
`include "rlws_map.vh"
module reset_lowpower_wake_sequencer #(
  parameter LOCK_MAX_REF = `LOCK_MAX_REF
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_q,
  output reg hreadyout_q,
  output reg hresp_q,
  // Reset pin, open drain
  input wire rst_pin_in,
  output reg rst_pin_out_q,
  output reg rst_pin_oe_n_q,
  // Events and status from the rest of the chip
  input wire wdog_trip,
  input wire pll_lock,
  input wire wake_irq,
  input wire power_drive_fault_input_n,
  input wire test_data_in,
  input wire test_reset_in,
  // Core control
  output reg core_run_q,
  output reg vec_fetch_q,
  output reg fault_vec_fetch_q,
  output reg osc_enable_q,
  output reg pll_enable_q,
  output reg [1:0] pll_mult_q,
  output reg boot_rom_sel_q,
  output reg boot_option_input_q,
  output reg core_output_clock_pin_q,
  // PWM pin
  output reg pwm_out_q,
  output reg pwm_oe_n_q
);
  // ==========================================================
  // Constants
  localparam [3:0] S_RST = 4'h0;
  localparam [3:0] S_LOCK = 4'h1;
  localparam [3:0] S_VEC = 4'h2;
  localparam [3:0] S_RUN = 4'h3;
  localparam [3:0] S_ENTER = 4'h4;
  localparam [3:0] S_SLEEP = 4'h5;
  localparam [3:0] S_WAKE = 4'h6;
  localparam [1:0] M_LIGHT = 2'h0;
  localparam [1:0] M_DEEP = 2'h1;
  localparam [1:0] M_HALT = 2'h2;
  // Counts are full words; each use takes the counter's width on purpose
  localparam [31:0] C_WD = `WD_PULSE_CYC;
  localparam [31:0] C_VEC = `VEC_CYC;
  localparam [31:0] C_LOCK = LOCK_MAX_REF * `REF_NS / `CLK_NS;
  localparam [31:0] C_STOP = `CORE_CYC(`STOP_CORE);
  localparam [31:0] C_WL = `CORE_CYC(`WAKE_LIGHT_CORE);
  localparam [31:0] C_WD2 = `CORE_CYC(`WAKE_DEEP_CORE);
  localparam [31:0] C_QS = `CORE_CYC(`QUAL_SHORT_CORE);
  localparam [31:0] C_QL = `CORE_CYC(`QUAL_LONG_CORE);
  localparam [31:0] C_SY = `CORE_CYC(`SYNC_CORE);
  // ==========================================================
  // State
  reg [3:0] st_q; // Sequencer state
  reg [16:0] cnt_q; // Shared delay counter
  reg wd_hold_q; // Watchdog pulse in progress
  reg [1:0] mode_q; // Low-power mode requested
  reg pwrdn_q; // Oscillator and PLL power-down requested
  reg halt_wake_q; // Lock wait belongs to a wake from power-down
  reg fault_wake_q; // Wake was caused by the fault input
  reg [1:0] mult_save_q; // Multiplier in force at power-down entry
  reg clk_q; // Internal core output clock
  reg mux_clk_q; // Core clock routed to the pin
  reg qual_long_q; // Qualifier length select
  reg [1:0] ien_q; // Bit 0 wake irq, bit 1 fault irq enable
  reg [1:0] mult_q; // Software multiplier
  reg [7:0] per_q; // PWM period in core periods
  reg [7:0] duty_q; // PWM duty in core periods
  reg cmp_en_q; // compare_output_enable_flag
  reg [7:0] pcnt_q; // PWM period counter
  reg [5:0] fcnt_q; // Fault low counter
  reg wr_q; // Write data phase pending
  reg [7:0] wa_q; // Write address
  reg [31:0] rd_d; // Read mux
  wire [5:0] qual = qual_long_q ? C_QL[5:0] : C_QS[5:0];
  wire fault_qual = (fcnt_q >= qual);
  wire fault_z = (fcnt_q == qual + C_SY[5:0]);
  wire lpc_wr = wr_q && (wa_q == `A_LPC);
  wire pwm_wr = wr_q && (wa_q == `A_PWM);
  wire take = hsel && htrans[1] && hready;
  // Core clock runs while executing and waking, and in light idle entry and sleep without power-down
  wire clk_run = (st_q == S_VEC) || (st_q == S_RUN) || (st_q == S_WAKE) ||
                 (st_q == S_ENTER && mode_q == M_LIGHT) ||
                 (st_q == S_SLEEP && mode_q == M_LIGHT && !pwrdn_q);
  // Stopped clock parks high
  wire clk_d = clk_run ? ~clk_q : 1'b1; // R5
  wire tick = ~clk_q & clk_d;
  // ==========================================================
  // Sequencer: reset, lock, vector delay, idle entry and wake
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_RST;
      cnt_q <= 17'h00000;
      wd_hold_q <= 1'b0;
      mode_q <= 2'h0;
      pwrdn_q <= 1'b0;
      halt_wake_q <= 1'b0;
      fault_wake_q <= 1'b0;
      mult_save_q <= `MULT_RST;
      pll_mult_q <= `MULT_RST;
      core_run_q <= 1'b0;
      vec_fetch_q <= 1'b0;
      fault_vec_fetch_q <= 1'b0;
      osc_enable_q <= 1'b1;
      pll_enable_q <= 1'b1;
      boot_rom_sel_q <= 1'b0;
      boot_option_input_q <= 1'b0;
      rst_pin_out_q <= 1'b0;
      rst_pin_oe_n_q <= 1'b1;
    end else begin
      vec_fetch_q <= 1'b0;
      fault_vec_fetch_q <= 1'b0;
      if (wdog_trip && !wd_hold_q) begin
        // Watchdog: drive the pin low and restart the whole sequence
        st_q <= S_RST;
        wd_hold_q <= 1'b1;
        rst_pin_oe_n_q <= 1'b0; // R19
        cnt_q <= 17'h00000; // R20
        core_run_q <= 1'b0;
        halt_wake_q <= 1'b0;
      end else if (!rst_pin_in && !wd_hold_q && st_q != S_RST) begin
        // Board holds the reset pin low
        st_q <= S_RST;
        cnt_q <= 17'h00000; // R20
        core_run_q <= 1'b0;
        halt_wake_q <= 1'b0;
      end else begin
        case (st_q)
          S_RST: begin
            osc_enable_q <= 1'b1;
            pll_enable_q <= 1'b1;
            pll_mult_q <= mult_q;
            boot_rom_sel_q <= test_data_in; // R11
            if (wd_hold_q) begin
              cnt_q <= cnt_q + 17'h00001;
              if (cnt_q == C_WD[16:0] - 17'h00001) begin // R1
                wd_hold_q <= 1'b0;
                rst_pin_oe_n_q <= 1'b1; // R19
                cnt_q <= 17'h00000;
              end
            end else if (rst_pin_in) begin
              st_q <= S_LOCK;
              cnt_q <= 17'h00000; // R20
            end
          end
          S_LOCK: begin
            cnt_q <= cnt_q + 17'h00001;
            // Proceed on lock or when the longest lock time has passed
            if (pll_lock || cnt_q == C_LOCK[16:0] - 17'h00001) begin // R3
              cnt_q <= 17'h00000;
              if (halt_wake_q) begin
                st_q <= S_WAKE; // R7
                pll_mult_q <= mult_save_q; // R16
              end else begin
                st_q <= S_VEC;
              end
            end
          end
          S_VEC: begin
            cnt_q <= cnt_q + 17'h00001;
            if (!test_reset_in) begin
              boot_option_input_q <= test_data_in; // R12
            end
            if (cnt_q == C_VEC[16:0] - 17'h00001) begin // R2 R8
              st_q <= S_RUN;
              core_run_q <= 1'b1;
              vec_fetch_q <= 1'b1;
              cnt_q <= 17'h00000;
            end
          end
          S_RUN: begin
            pll_mult_q <= mult_q;
            if (lpc_wr && hwdata[1:0] != 2'h3) begin
              st_q <= S_ENTER;
              mode_q <= hwdata[1:0];
              pwrdn_q <= hwdata[2] || (hwdata[1:0] == M_HALT);
              core_run_q <= 1'b0;
              cnt_q <= 17'h00000; // R20
            end
          end
          S_ENTER: begin
            cnt_q <= cnt_q + 17'h00001;
            if (cnt_q == C_STOP[16:0] - 17'h00001) begin // R5 R6
              st_q <= S_SLEEP;
              cnt_q <= 17'h00000;
              if (pwrdn_q) begin
                osc_enable_q <= 1'b0;
                pll_enable_q <= 1'b0;
                mult_save_q <= pll_mult_q;
              end
            end
          end
          S_SLEEP: begin
            // Halt wakes on the fault input only; idle on any enabled irq
            if (mode_q == M_HALT ? fault_qual :
                ((wake_irq && ien_q[0]) || (fault_qual && ien_q[1]))) begin // R9
              fault_wake_q <= fault_qual;
              cnt_q <= 17'h00000; // R20
              if (pwrdn_q) begin
                st_q <= S_LOCK;
                halt_wake_q <= 1'b1;
                osc_enable_q <= 1'b1; // R7
                pll_enable_q <= 1'b1;
              end else begin
                st_q <= S_WAKE;
              end
            end
          end
          S_WAKE: begin
            cnt_q <= cnt_q + 17'h00001;
            if (cnt_q == (mode_q == M_LIGHT ? C_WL[16:0] : C_WD2[16:0]) - 17'h00001) begin // R4
              st_q <= S_RUN;
              core_run_q <= 1'b1;
              halt_wake_q <= 1'b0;
              cnt_q <= 17'h00000;
              vec_fetch_q <= !fault_wake_q;
              fault_vec_fetch_q <= fault_wake_q && ien_q[1]; // R15 R17
            end
          end
          default: begin
            st_q <= S_RST;
            cnt_q <= 17'h00000;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Core clock, fault qualifier and PWM
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_q <= 1'b1;
      core_output_clock_pin_q <= 1'b0;
      fcnt_q <= 6'h00;
      pcnt_q <= 8'h00;
      cmp_en_q <= 1'b1;
      pwm_out_q <= 1'b0;
      pwm_oe_n_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      core_output_clock_pin_q <= mux_clk_q & clk_d; // R10
      // Count low cycles, saturating at the tri-state point
      if (power_drive_fault_input_n) begin
        fcnt_q <= 6'h00;
      end else if (!fault_z) begin
        fcnt_q <= fcnt_q + 6'h01; // R14
      end
      // Fault clear beats a software set in the same cycle
      if (fault_z) begin
        cmp_en_q <= 1'b0; // R13
      end else if (pwm_wr) begin
        cmp_en_q <= hwdata[`PWM_CMP_BIT];
      end
      pwm_oe_n_q <= ~cmp_en_q || fault_z; // R13
      if (tick) begin
        pcnt_q <= (pcnt_q + 8'h01 >= per_q) ? 8'h00 : pcnt_q + 8'h01;
      end
      // Full duty when duty reaches the period, even when both are zero; none when only duty is zero
      pwm_out_q <= (duty_q >= per_q) || (pcnt_q < duty_q); // R18
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  always @* begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `A_MUX: rd_d[`MUX_CLK_BIT] = mux_clk_q;
      `A_SCS2: rd_d[`SCS2_QUAL_BIT] = qual_long_q;
      `A_LPC: rd_d[2:0] = {pwrdn_q, mode_q};
      `A_IEN: rd_d[1:0] = ien_q;
      `A_PWM: rd_d[16:0] = {cmp_en_q, duty_q, per_q};
      `A_STAT: rd_d[11:0] = {pll_mult_q, fault_wake_q, halt_wake_q, osc_enable_q,
                             core_run_q, boot_option_input_q, boot_rom_sel_q, st_q};
      `A_MULT: rd_d[1:0] = mult_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end
  // Register writes land in the data phase
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      mux_clk_q <= 1'b0;
      qual_long_q <= 1'b0;
      ien_q <= 2'h0;
      mult_q <= `MULT_RST;
      per_q <= 8'h00;
      duty_q <= 8'h00;
    end else begin
      wr_q <= take && hwrite;
      wa_q <= haddr[7:0];
      if (take && !hwrite) begin
        hrdata_q <= rd_d;
      end
      if (st_q == S_RST) begin
        mux_clk_q <= 1'b0; // R10
      end else if (wr_q && wa_q == `A_MUX) begin
        mux_clk_q <= hwdata[`MUX_CLK_BIT]; // R10
      end
      if (wr_q && wa_q == `A_SCS2) begin
        qual_long_q <= hwdata[`SCS2_QUAL_BIT];
      end
      if (wr_q && wa_q == `A_IEN) begin
        ien_q <= hwdata[1:0];
      end
      if (wr_q && wa_q == `A_MULT) begin
        mult_q <= hwdata[1:0];
      end
      if (pwm_wr) begin
        per_q <= hwdata[7:0];
        duty_q <= hwdata[15:8];
      end
    end
  end
endmodule

// [testbench/rlws_sva.sv]
// Checker for the sequencer top ports.
// Assumes one clk_sys domain and an asynchronous active-low arst_n.
`timescale 1ns/100ps
module rlws_sva (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Watched pins
  input wire power_drive_fault_input_n,
  input wire hreadyout_q,
  input wire hresp_q,
  input wire rst_pin_out_q,
  input wire rst_pin_oe_n_q,
  input wire core_run_q,
  input wire vec_fetch_q,
  input wire fault_vec_fetch_q,
  input wire core_output_clock_pin_q,
  input wire pwm_oe_n_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ========
  // Saturating counts of pin drive and fault low
  reg [7:0] drv_q;
  reg [7:0] flt_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drv_q <= 8'h00;
      flt_q <= 8'h00;
    end else begin
      drv_q <= rst_pin_oe_n_q ? 8'h00 : drv_q + {7'h00, drv_q != 8'hff};
      flt_q <= power_drive_fault_input_n ? 8'h00 : flt_q + {7'h00, flt_q != 8'hff};
    end
  end
  // End of a device-driven reset pulse
  sequence drv_end;
    $rose(rst_pin_oe_n_q);
  endsequence
  AST_READY: assert property (hreadyout_q) else $error("Bus stalled");
  AST_OKAY: assert property (!hresp_q) else $error("Error response");
  AST_PIN_LOW: assert property (!rst_pin_out_q) else $error("Pin data high");
  AST_WD_WIDTH: assert property (drv_end |-> drv_q >= 8'h80 && drv_q <= 8'h82)
    else $error("Reset pulse width wrong");
  AST_VEC_RUN: assert property (vec_fetch_q |-> core_run_q) else $error("Fetch idle");
  AST_VEC_ONE: assert property (vec_fetch_q |=> !vec_fetch_q) else $error("Long fetch");
  AST_FVEC_ONE: assert property (fault_vec_fetch_q |=> !fault_vec_fetch_q)
    else $error("Long fault fetch");
  AST_PIN_RST: assert property (!$past(arst_n) |-> !core_output_clock_pin_q)
    else $error("Core clock on pin after reset");
  AST_PWM_OFF: assert property (flt_q == 8'h1c |-> pwm_oe_n_q)
    else $error("PWM still driven");
  // Watchdog reset clears the pin route within two edges of the pin drive
  AST_WD_PIN_CLK: assert property (!rst_pin_oe_n_q |-> ##2 !core_output_clock_pin_q)
    else $error("Core clock on pin during watchdog reset");
endmodule

bind reset_lowpower_wake_sequencer rlws_sva chk_i (
  .clk_sys(clk_sys), .arst_n(arst_n), .power_drive_fault_input_n(power_drive_fault_input_n),
  .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .rst_pin_out_q(rst_pin_out_q),
  .rst_pin_oe_n_q(rst_pin_oe_n_q), .core_run_q(core_run_q), .vec_fetch_q(vec_fetch_q),
  .fault_vec_fetch_q(fault_vec_fetch_q), .core_output_clock_pin_q(core_output_clock_pin_q),
  .pwm_oe_n_q(pwm_oe_n_q));

// [testbench/board_model.sv]
// Board side: pulled-up reset pin, PLL lock and fault pin.
// Assumes the bench sets hold_n and lock_dly by hierarchy.
`timescale 1ns/100ps
module board_model (
  // Clock
  input wire clk_sys,
  // From the device
  input wire rst_pin_oe_n_q,
  input wire pll_enable_q,
  // To the device
  output wire rst_pin_in,
  output reg pll_lock,
  output reg power_drive_fault_input_n
);
  reg hold_n; // Board reset switch
  integer lock_dly; // Slow or prompt lock
  integer lock_cnt;
  // Open drain: any party pulls low, else the pull-up wins
  assign rst_pin_in = hold_n & rst_pin_oe_n_q;
  initial begin
    hold_n = 1'b0;
    lock_dly = 5;
    lock_cnt = 0;
    pll_lock = 1'b0;
    power_drive_fault_input_n = 1'b1;
  end
  // Lock needs a full delay of a running PLL with the pin released
  always @(posedge clk_sys) begin
    if (!pll_enable_q || !rst_pin_in) begin
      lock_cnt <= 0;
    end else if (lock_cnt < lock_dly) begin
      lock_cnt <= lock_cnt + 1;
    end
    pll_lock <= pll_enable_q && rst_pin_in && lock_cnt >= lock_dly;
  end
  // Fault held low for whole cycles
  task fault_low(input integer n);
    power_drive_fault_input_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    power_drive_fault_input_n <= 1'b1;
  endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the reset and wake sequencer.
// Assumes the board model on the pins and a 10 MHz clk_sys.
`timescale 1ns/100ps
module testbench;
  // ========
  // Stimulus and observed pins
  reg clk_sys, arst_n, hsel, hwrite, wdog_trip, wake_irq, test_data_in, test_reset_in;
  reg [31:0] haddr, hwdata, rd;
  reg [1:0] htrans;
  reg [103:0] rows [0:5]; // Address, write data, reset value, read-back
  wire [31:0] hrdata_q;
  wire hreadyout_q, hresp_q, rst_pin_in, rst_pin_out_q, rst_pin_oe_n_q, pll_lock, flt_n;
  wire core_run_q, vec_fetch_q, fault_vec_fetch_q, osc_enable_q, pll_enable_q;
  wire [1:0] pll_mult_q;
  wire boot_rom_sel_q, boot_option_input_q, core_output_clock_pin_q, pwm_out_q, pwm_oe_n_q;
  integer miscompares, checked, cyc, fv, n, i;
  // Short lock cap keeps the run brief
  reset_lowpower_wake_sequencer #(.LOCK_MAX_REF(64)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q),
    .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
    .rst_pin_in(rst_pin_in), .rst_pin_out_q(rst_pin_out_q), .rst_pin_oe_n_q(rst_pin_oe_n_q),
    .wdog_trip(wdog_trip), .pll_lock(pll_lock), .wake_irq(wake_irq),
    .power_drive_fault_input_n(flt_n), .test_data_in(test_data_in),
    .test_reset_in(test_reset_in), .core_run_q(core_run_q), .vec_fetch_q(vec_fetch_q),
    .fault_vec_fetch_q(fault_vec_fetch_q), .osc_enable_q(osc_enable_q),
    .pll_enable_q(pll_enable_q), .pll_mult_q(pll_mult_q), .boot_rom_sel_q(boot_rom_sel_q),
    .boot_option_input_q(boot_option_input_q), .pwm_out_q(pwm_out_q),
    .core_output_clock_pin_q(core_output_clock_pin_q), .pwm_oe_n_q(pwm_oe_n_q));
  board_model board (.clk_sys(clk_sys), .rst_pin_oe_n_q(rst_pin_oe_n_q),
    .pll_enable_q(pll_enable_q), .rst_pin_in(rst_pin_in), .pll_lock(pll_lock),
    .power_drive_fault_input_n(flt_n));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard and fault-vector count
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (fault_vec_fetch_q === 1'b1) fv = fv + 1;
    if (cyc == 6000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single word transfer; no wait count is assumed
  task bus(input [7:0] a, input w, input [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (!hreadyout_q) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hreadyout_q) @(posedge clk_sys);
    rd = hrdata_q;
    hsel <= 1'b0;
  endtask
  function logic pick(input integer k);
    case (k)
      0: pick = vec_fetch_q;
      1: pick = core_run_q;
      2: pick = osc_enable_q;
      default: pick = rst_pin_oe_n_q;
    endcase
  endfunction
  // Cycles until a watched output reaches a level
  task wait_on(input integer k, input logic v);
    n = 0;
    while (pick(k) !== v) begin
      @(posedge clk_sys);
      n = n + 1;
    end
  endtask
  // Reset for 20 cycles, then time release to the vector fetch
  task boot(input td, input tr, input integer ld);
    arst_n <= 1'b0;
    board.hold_n <= 1'b0;
    test_data_in <= td;
    test_reset_in <= tr;
    board.lock_dly = ld;
    repeat (20) @(posedge clk_sys);
    chk("rst_vals", {core_run_q, pll_mult_q, rst_pin_oe_n_q, core_output_clock_pin_q}, 5'h0e);
    arst_n <= 1'b1;
    board.hold_n <= 1'b1;
    wait_on(0, 1'b1);
    ld = (ld < 64 ? ld : 64) + 36;
    chk("boot_delay", n >= ld && n <= ld + 6, 1);
    chk("boot_pins", {boot_rom_sel_q, boot_option_input_q}, {td, td & !tr});
    $display("boot test done");
  endtask
  task tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {hsel, hwrite, wdog_trip, wake_irq, test_data_in, test_reset_in} = 6'h0;
    {haddr, hwdata, htrans, arst_n} = 0;
    {miscompares, checked, cyc, fv} = 0;
    rows[0] = {8'h00, 32'h80, 32'h0, 32'h80};
    rows[1] = {8'h04, 32'h40, 32'h0, 32'h40};
    rows[2] = {8'h0c, 32'h3, 32'h0, 32'h3};
    rows[3] = {8'h10, 32'h1_0204, 32'h1_0000, 32'h1_0204};
    rows[4] = {8'h18, 32'h1, 32'h3, 32'h1};
    rows[5] = {8'h20, 32'hffff_ffff, 32'h0, 32'h0};
    boot(1'b1, 1'b1, 5);
    for (i = 0; i < 6; i = i + 1) begin
      bus(rows[i][103:96], 1'b0, 32'h0);
      chk("reg_reset", rd, rows[i][63:32]);
      bus(rows[i][103:96], 1'b1, rows[i][95:64]);
      bus(rows[i][103:96], 1'b0, 32'h0);
      chk("reg_back", rd, rows[i][31:0]);
    end
    $display("register test done");
    // Light then deep idle: masked wake first, then enabled
    for (i = 0; i < 2; i = i + 1) begin
      bus(8'h0c, 1'b1, 32'h0);
      bus(8'h08, 1'b1, i);
      wake_irq <= 1'b1;
      repeat (40) @(posedge clk_sys);
      chk("masked_wake", core_run_q, 0);
      if (i == 1) chk("clk_park", core_output_clock_pin_q, 1);
      bus(8'h0c, 1'b1, 32'h3);
      wait_on(0, 1'b1);
      chk("idle_wake", n >= 24 + 6 * i && n <= 28 + 6 * i, 1);
      wake_irq <= 1'b0;
    end
    $display("idle test done");
    // Halt with fault vector enabled, then disabled
    for (i = 0; i < 2; i = i + 1) begin
      fv = 0;
      bus(8'h0c, 1'b1, 32'h2 >> i);
      bus(8'h08, 1'b1, 32'h2);
      wait_on(2, 1'b0);
      chk("osc_off", n >= 7 && n <= 11, 1);
      board.fault_low(24);
      wait_on(1, 1'b1);
      chk("wake_time", n <= 20 + 24, 1);
      chk("lock_first", {pll_lock, osc_enable_q, pll_mult_q}, 4'hd);
      repeat (4) @(posedge clk_sys);
      chk("fault_vec", fv, 1 - i);
      chk("pwm_kept", pwm_oe_n_q, 0);
    end
    $display("halt test done");
    board.fault_low(30);
    @(posedge clk_sys);
    chk("pwm_tri", pwm_oe_n_q, 1);
    // Duty 0, duty equal to period, then half the period
    for (i = 0; i < 3; i = i + 1) begin
      bus(8'h10, 1'b1, 32'h1_0004 | (i == 2 ? 32'h200 : i * 32'h400));
      repeat (10) @(posedge clk_sys);
      chk("pwm_drive", pwm_oe_n_q, 0);
      n = 0;
      repeat (8) @(posedge clk_sys) n = n + pwm_out_q;
      chk("pwm_duty", n, i == 2 ? 4 : 8 * i);
    end
    $display("pwm test done");
    wdog_trip <= 1'b1;
    @(posedge clk_sys);
    wdog_trip <= 1'b0;
    wait_on(3, 1'b0);
    wait_on(3, 1'b1);
    chk("wd_pulse", n >= 128 && n <= 130, 1);
    wait_on(0, 1'b1);
    bus(8'h00, 1'b0, 32'h0);
    chk("mux_clear", rd, 0);
    $display("watchdog test done");
    boot(1'b1, 1'b0, 500);
    tally_and_finish;
  end
endmodule
